/* inc/isfe_cfg.svh */
// isfe_cfg.svh: register offsets, field positions, reset values and filter timing
// assumes: included by the package and design files by bare name
`ifndef ISFE_CFG_SVH
`define ISFE_CFG_SVH

// control register offset and reset value
`define ISFE_CTRL_ADDR 8'h37
`define ISFE_CTRL_RESET 8'h00
// control register fields
`define ISFE_B_TRIG_BIT 1
`define ISFE_D_TRIG_LO 2
`define ISFE_C_TRIG_LO 4
`define ISFE_A_PIN_SEL_BIT 6
`define ISFE_B_FILT_SEL_BIT 7
// opcode and address areas
`define ISFE_TRAP_OPCODE 8'hff
`define ISFE_SFA_LO 16'h0000
`define ISFE_SFA_HI 16'h003f
`define ISFE_DBA_LO 16'h0f80
`define ISFE_DBA_HI 16'h0fff
// filter stable counts in filter clock periods (fc ticks or fs ticks)
`define ISFE_CNT_AE_FAST 8'h0004
`define ISFE_CNT_B_LONG 8'h003f
`define ISFE_CNT_B_SHORT 8'h000f
`define ISFE_CNT_CD_FAST 8'h0007
`define ISFE_CNT_SLOW 8'h0002
// filter-select change latency in fc periods
`define ISFE_B_SEL_DELAY 7'h40

`endif

/* inc/isfe_pkg.sv */
// isfe_pkg.sv: types of the interrupt source front end
// assumes: isfe_cfg.svh on the include path
`include "isfe_cfg.svh"
package isfe_pkg;
  // trigger selection for the two-bit fields
  typedef enum logic [1:0] {
    isfe_trig_rise_type_e = 2'h0,
    isfe_trig_fall_type_e = 2'h1,
    isfe_trig_both_type_e = 2'h2,
    isfe_trig_high_type_e = 2'h3
  } isfe_trig_type;
  // guard-fetch response state
  typedef enum logic [2:0] {
    isfe_st_idle = 3'b001,
    isfe_st_irq = 3'b010,
    isfe_st_rst = 3'b100
  } isfe_guard_type;
endpackage : isfe_pkg

/* hdl/isfe_filter.sv */
// isfe_filter.sv: one digital noise filter with edge or level detector
// assumes: i_pin already synchronised; i_tick marks one filter clock period
`timescale 1ns/10ps
`include "isfe_cfg.svh"
module isfe_filter #(
  parameter int CW = 8
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // sample input
  input wire logic i_pin,
  input wire logic i_tick,
  input wire logic [CW-1:0] i_count,
  input wire logic [1:0] i_trig,
  // detected event
  output logic o_event,
  output logic o_level
);
  logic [CW-1:0] stable_cnt;
  logic filt;
  logic filt_q;
  logic armed;

  // count samples that differ from the filtered level; a sample equal to it restarts the window
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stable_cnt <= '0;
    end else if (i_pin == filt) begin
      stable_cnt <= '0;
    end else if (i_tick) begin
      stable_cnt <= stable_cnt + CW'(1);
    end
  end

  // the new level is passed on only after the full stable count
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      filt <= 1'b0;
    end else if (i_pin != filt && i_tick && stable_cnt + CW'(1) >= i_count) begin
      filt <= i_pin;
    end
  end

  // previous filtered level for edge detection
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      filt_q <= 1'b0;
    end else begin
      filt_q <= filt;
    end
  end

  // level mode is armed only by a rising edge seen after reset
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      armed <= 1'b0;
    end else if (filt && !filt_q) begin
      armed <= 1'b1;
    end
  end

  // one-cycle event per detected edge, or per cycle while armed level is high
  always_comb begin
    case (i_trig)
      isfe_pkg::isfe_trig_rise_type_e: o_event = filt && !filt_q;
      isfe_pkg::isfe_trig_fall_type_e: o_event = !filt && filt_q;
      isfe_pkg::isfe_trig_both_type_e: o_event = filt ^ filt_q;
      isfe_pkg::isfe_trig_high_type_e: o_event = filt && armed && filt_q;
      default: o_event = 1'b0;
    endcase
  end
  assign o_level = filt;
endmodule : isfe_filter

/* hdl/isfe_front_end.sv */
// isfe_front_end.sv: interrupt source front end
// assumes: CPU core supplies fetch/decode strobes; enables come from the enable register
// Operation
// - trap opcode execution raises the trap interrupt at once, highest priority
// - fetch from nonexistent address in single-chip mode returns the trap opcode
// - fetch from RAM, data buffer or special function area triggers fetch guard
// - undefined opcode raises bad-opcode interrupt, preempting non-maskable service
// - fetch-guard interrupt is accepted even during non-maskable service
// - guard timer control setting chooses reset output or fetch-guard interrupt
// - five external inputs, each with a digital noise filter
// - shared pin of input a is a port pin until pin-select is 1
// - inputs a and e fall-edge only, reject under 2/fc, accept 7/fc
// - input b accepts 49/fc short filter, 193/fc long filter
// - input b filter-select 0 rejects under 63/fc, 1 under 15/fc
// - input b filter-select change takes effect within 2^6 fc periods
// - inputs c and d reject under 7/fc, accept 25/fc on fc
// - low-speed and sleep modes reject under 1/fs, accept 3.5/fs
// - c and d trigger: 00 rise, 01 fall, 10 both, 11 high level
// - b trigger: 0 rising edge, 1 falling edge
// - requests need master enable, own enable, and a/c extra selects
// - with pin-select 0, input a falling edge leaves its latch clear
// - clean edge sets latch within establishment time plus 6/fs
// - high level on c or d at reset release is still detected; filt resets low, so the filtered rise of that level arms it
// - output changes on shared pins look like input transitions
// - pending latch holds until accepted, reset or instruction clear
`timescale 1ns/10ps
`include "isfe_cfg.svh"
module isfe_front_end #(
  parameter int NUM_EXT = 5,
  parameter int CW = 8
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // low-frequency tick and slow mode
  input wire logic i_fs_tick,
  input wire logic i_slow_mode,
  // control register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // enables from the enable register
  input wire logic i_master_irq_enable,
  input wire logic [NUM_EXT-1:0] i_ext_enable_flag,
  input wire logic i_shared_level_source_select,
  input wire logic i_guard_reset_select,
  // cpu fetch and decode strobes
  input wire logic i_fetch,
  input wire logic [15:0] i_fetch_addr,
  input wire logic i_fetch_exists,
  input wire logic i_single_chip,
  input wire logic [7:0] i_mem_data,
  input wire logic i_exec_valid,
  input wire logic [7:0] i_exec_opcode,
  input wire logic i_exec_undefined,
  input wire logic i_ram_fetch,
  // pending latch acceptance and software clear
  input wire logic [NUM_EXT-1:0] i_ext_accept,
  input wire logic [NUM_EXT-1:0] i_ext_clear,
  // external pins: a, b, c, d, e
  input wire logic [NUM_EXT-1:0] i_ext_pin,
  // outputs
  output logic [7:0] o_fetch_data,
  output logic o_trap_instr_irq,
  output logic o_bad_opcode_irq,
  output logic o_fetch_guard_irq,
  output logic o_guard_reset,
  output logic o_port1_bit0_is_port,
  output logic [NUM_EXT-1:0] o_ext_pending
);

  ////////////////////////////////////////////////////////////////////////////
  // control register
  logic [7:0] ext_irq_control;
  logic ext_a_pin_select;
  logic ext_b_filter_select;
  logic ext_b_filter_eff;
  logic [6:0] sel_delay;

  // register write; reads decode the same address
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ext_irq_control <= `ISFE_CTRL_RESET;
    end else if (i_reg_wr && i_reg_addr == `ISFE_CTRL_ADDR) begin
      ext_irq_control <= i_reg_wdata;
    end
  end
  assign o_reg_rdata = (i_reg_addr == `ISFE_CTRL_ADDR) ?
                       {ext_irq_control[7:1], 1'b0} : 8'h00;
  assign ext_a_pin_select = ext_irq_control[`ISFE_A_PIN_SEL_BIT];
  assign ext_b_filter_select = ext_irq_control[`ISFE_B_FILT_SEL_BIT];
  assign o_port1_bit0_is_port = !ext_a_pin_select;

  // filter-select change is adopted after a fixed delay of 2^6 fc
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel_delay <= '0;
      ext_b_filter_eff <= 1'b0;
    end else if (ext_b_filter_eff == ext_b_filter_select) begin
      sel_delay <= '0;
    end else if (sel_delay == `ISFE_B_SEL_DELAY - 7'h01) begin
      ext_b_filter_eff <= ext_b_filter_select;
      sel_delay <= '0;
    end else begin
      sel_delay <= sel_delay + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fetch guard and cpu interrupts
  isfe_pkg::isfe_guard_type guard_state;
  logic guarded;

  function automatic logic in_guard(input logic [15:0] a, input logic ram);
    in_guard = ram || (a <= `ISFE_SFA_HI) ||
               (a >= `ISFE_DBA_LO && a <= `ISFE_DBA_HI);
  endfunction : in_guard

  assign guarded = i_fetch && in_guard(i_fetch_addr, i_ram_fetch);

  // nonexistent fetch in single-chip mode returns the trap opcode
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_fetch_data <= `ISFE_TRAP_OPCODE;
    end else if (i_fetch) begin
      o_fetch_data <= (i_single_chip && !i_fetch_exists) ? `ISFE_TRAP_OPCODE
                      : i_mem_data;
    end
  end

  // trap and bad-opcode requests are immediate; priority resolved downstream
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_trap_instr_irq <= 1'b0;
      o_bad_opcode_irq <= 1'b0;
    end else begin
      o_trap_instr_irq <= i_exec_valid && i_exec_opcode == `ISFE_TRAP_OPCODE;
      o_bad_opcode_irq <= i_exec_valid && i_exec_undefined;
    end
  end

  // guarded fetch: reset output or interrupt, chosen by the guard timer control
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      guard_state <= isfe_pkg::isfe_st_idle;
    end else begin
      case (guard_state)
        isfe_pkg::isfe_st_idle: begin
          if (guarded) begin
            guard_state <= i_guard_reset_select ? isfe_pkg::isfe_st_rst
                                                : isfe_pkg::isfe_st_irq;
          end
        end
        isfe_pkg::isfe_st_irq: guard_state <= isfe_pkg::isfe_st_idle;
        isfe_pkg::isfe_st_rst: guard_state <= isfe_pkg::isfe_st_idle;
        default: guard_state <= isfe_pkg::isfe_st_idle;
      endcase
    end
  end
  // not masked by any service in progress, so it preempts non-maskable work
  assign o_fetch_guard_irq = guard_state == isfe_pkg::isfe_st_irq;
  assign o_guard_reset = guard_state == isfe_pkg::isfe_st_rst;

  ////////////////////////////////////////////////////////////////////////////
  // external inputs: synchronise, filter, detect, latch
  logic [NUM_EXT-1:0] pin_meta;
  logic [NUM_EXT-1:0] pin_sync;
  logic [NUM_EXT-1:0] ext_event;
  logic [NUM_EXT-1:0] ext_allow;
  logic [NUM_EXT-1:0][CW-1:0] cnt_sel;
  logic [NUM_EXT-1:0][1:0] trig_sel;
  logic filt_tick;

  // two-flop synchroniser; output-driven pin changes pass like any input
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= i_ext_pin;
      pin_sync <= pin_meta;
    end
  end

  // fc counts every clock; slow and sleep modes count fs periods
  assign filt_tick = i_slow_mode ? i_fs_tick : 1'b1;

  // per-input stable counts and trigger modes
  always_comb begin
    cnt_sel = '0;
    trig_sel = '0;
    if (i_slow_mode) begin
      cnt_sel[0] = CW'(`ISFE_CNT_SLOW);
      cnt_sel[1] = CW'(`ISFE_CNT_SLOW);
      cnt_sel[2] = CW'(`ISFE_CNT_SLOW);
      cnt_sel[3] = CW'(`ISFE_CNT_SLOW);
      cnt_sel[4] = CW'(`ISFE_CNT_SLOW);
    end else begin
      cnt_sel[0] = CW'(`ISFE_CNT_AE_FAST);
      // long window 63 sits below the 193/fc acceptance, short 15 below 49/fc
      cnt_sel[1] = ext_b_filter_eff ? CW'(`ISFE_CNT_B_SHORT)
                                    : CW'(`ISFE_CNT_B_LONG);
      cnt_sel[2] = CW'(`ISFE_CNT_CD_FAST);
      cnt_sel[3] = CW'(`ISFE_CNT_CD_FAST);
      cnt_sel[4] = CW'(`ISFE_CNT_AE_FAST);
    end
    trig_sel[0] = isfe_pkg::isfe_trig_fall_type_e;
    // input b has only one trigger bit: 0 rising, 1 falling
    trig_sel[1] = ext_irq_control[`ISFE_B_TRIG_BIT] ? isfe_pkg::isfe_trig_fall_type_e
                                                     : isfe_pkg::isfe_trig_rise_type_e;
    trig_sel[2] = ext_irq_control[`ISFE_C_TRIG_LO +: 2];
    trig_sel[3] = ext_irq_control[`ISFE_D_TRIG_LO +: 2];
    trig_sel[4] = isfe_pkg::isfe_trig_fall_type_e;
  end

  // one filter per input
  genvar g;
  generate
    for (g = 0; g < NUM_EXT; g++) begin : g_ext
      isfe_filter #(.CW(CW)) u_filt (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_pin(pin_sync[g]),
        .i_tick(filt_tick),
        .i_count(cnt_sel[g]),
        .i_trig(trig_sel[g]),
        .o_event(ext_event[g]),
        .o_level()
      );
    end
  endgenerate

  // acceptance gating
  always_comb begin
    ext_allow = {NUM_EXT{i_master_irq_enable}} & i_ext_enable_flag;
    ext_allow[0] = ext_allow[0] && ext_a_pin_select;
    ext_allow[2] = ext_allow[2] && i_shared_level_source_select;
  end

  // pending latch: set wins over clear; held until accepted or cleared
  // latency is sync plus filter plus detect, well inside establishment plus 6/fs
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ext_pending <= '0;
    end else begin
      o_ext_pending <= (ext_event & ext_allow) |
                       (o_ext_pending & ~(i_ext_accept | i_ext_clear));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  a_trap_raise: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_exec_valid && i_exec_opcode == `ISFE_TRAP_OPCODE |=> o_trap_instr_irq)
    else $error("trap opcode did not raise trap irq");
  a_bad_opcode: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_exec_valid && i_exec_undefined |=> o_bad_opcode_irq)
    else $error("undefined opcode missed");
  a_missing_fetch: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_fetch && i_single_chip && !i_fetch_exists |=> o_fetch_data == `ISFE_TRAP_OPCODE)
    else $error("nonexistent fetch not trap opcode");
  a_guard_route: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    guarded && guard_state == isfe_pkg::isfe_st_idle |=>
    (o_guard_reset == $past(i_guard_reset_select)) && (o_fetch_guard_irq != o_guard_reset))
    else $error("guard response wrong");
  a_guard_sfa: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_fetch && i_fetch_addr <= `ISFE_SFA_HI && guard_state == isfe_pkg::isfe_st_idle
    |=> o_fetch_guard_irq || o_guard_reset)
    else $error("sfa fetch not guarded");
  a_pin_port: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !ext_a_pin_select |=> !$rose(o_ext_pending[0]))
    else $error("ext a latched while port");
  a_latch_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_ext_pending[1] && !i_ext_accept[1] && !i_ext_clear[1] |=> o_ext_pending[1])
    else $error("pending latch dropped");
  a_gate_master: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !i_master_irq_enable && !o_ext_pending[3] |=> !o_ext_pending[3])
    else $error("latch set without master enable");
  a_sel_delay: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $changed(ext_b_filter_select) |-> ##[1:64] ext_b_filter_eff == ext_b_filter_select)
    else $error("filter select slow");
  // latch e may only rise from a gated event of the cycle before
  a_set_source: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(o_ext_pending[4]) |-> $past(ext_event[4] && ext_allow[4]))
    else $error("pending rose without event");
  // an existing fetch passes the memory byte unchanged
  a_fetch_pass: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_fetch && i_fetch_exists |=> o_fetch_data == $past(i_mem_data))
    else $error("fetch data not passed");
  c_trap: cover property (@(posedge i_clk) o_trap_instr_irq);
  c_guard_irq: cover property (@(posedge i_clk) o_fetch_guard_irq);
  c_guard_rst: cover property (@(posedge i_clk) o_guard_reset);
  c_ext_b: cover property (@(posedge i_clk) $rose(o_ext_pending[1]));
  c_ext_c_level: cover property (@(posedge i_clk)
    trig_sel[2] == isfe_pkg::isfe_trig_high_type_e && $rose(o_ext_pending[2]));
endmodule : isfe_front_end

/* bench/isfe_pin_source.sv */
// isfe_pin_source.sv: model of the signal sources wired to the five interrupt pins
// assumes: the bench calls its tasks; pins change only just after a rising edge
`timescale 1ns/10ps
module isfe_pin_source (
  // clock
  input wire logic i_clk,
  // pin levels: a, b, c, d, e
  output logic [4:0] o_pin
);
  ////////////////////////////////////////////////////////////////////////////
  // sources rest low so that no edge reaches the filters at reset release
  initial o_pin = 5'h00;

  ////////////////////////////////////////////////////////////////////////////
  // clean level change; no bounce, so filter timing alone decides acceptance
  task automatic set_pin(input int idx, input logic lvl);
    @(posedge i_clk);
    o_pin[idx] <= lvl;
  endtask : set_pin

  // high pulse of w clock cycles, then back to rest
  task automatic pulse(input int idx, input int w);
    set_pin(idx, 1'b1);
    repeat (w - 1) @(posedge i_clk);
    set_pin(idx, 1'b0);
  endtask : pulse
endmodule : isfe_pin_source

/* bench/isfe_front_end_tb_top.sv */
// isfe_front_end_tb_top.sv: self-checking bench for the interrupt source front end
// assumes: pin sources modelled by isfe_pin_source; 40 MHz clock stands for fc
`timescale 1ns/10ps
module isfe_front_end_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, fs_tick = 1'b0, slow = 1'b0, wr = 1'b0;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata, mdata = 8'h5a, xop = 8'h00, fdata;
  logic master_irq_enable = 1'b1, lvl = 1'b1, gsel = 1'b0, fetch = 1'b0, fex = 1'b1, single = 1'b1;
  logic xv = 1'b0, xund = 1'b0, ram = 1'b0, trap, bad, gi, gr, port_is;
  logic [15:0] faddr = 16'h0000;
  logic [4:0] en = 5'h1f, acc = 5'h00, clr_v = 5'h00, pins, pend;
  logic [2:0] fs_cnt = 3'h0;
  logic [2:0] pat [4] = '{3'b100, 3'b001, 3'b101, 3'b111};
  int n_errors = 0, checks_done = 0;

  ////////////////////////////////////////////////////////////////////////////
  // 25 ns clock; low-frequency tick every 8 cycles
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    fs_cnt <= fs_cnt + 3'h1;
    fs_tick <= (fs_cnt == 3'h7);
  end

  isfe_pin_source src (.i_clk(clk), .o_pin(pins));
  isfe_front_end dut (.i_clk(clk), .i_reset_n(rst_n), .i_fs_tick(fs_tick),
    .i_slow_mode(slow), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wd),
    .o_reg_rdata(rdata), .i_master_irq_enable(master_irq_enable), .i_ext_enable_flag(en),
    .i_shared_level_source_select(lvl), .i_guard_reset_select(gsel), .i_fetch(fetch),
    .i_fetch_addr(faddr), .i_fetch_exists(fex), .i_single_chip(single),
    .i_mem_data(mdata), .i_exec_valid(xv), .i_exec_opcode(xop), .i_exec_undefined(xund),
    .i_ram_fetch(ram), .i_ext_accept(acc), .i_ext_clear(clr_v), .i_ext_pin(pins),
    .o_fetch_data(fdata), .o_trap_instr_irq(trap), .o_bad_opcode_irq(bad),
    .o_fetch_guard_irq(gi), .o_guard_reset(gr), .o_port1_bit0_is_port(port_is),
    .o_ext_pending(pend));

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // let n edges pass, then look mid-cycle where outputs are settled
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    @(negedge clk);
    chk("reg_rdata", e, rdata);
  endtask : rd

  // interrupts held off across the rewrite; wait covers the filter-select latency
  task automatic wr_ctrl(input logic [7:0] v);
    logic keep;
    keep = master_irq_enable;
    @(posedge clk);
    master_irq_enable <= 1'b0;
    @(posedge clk);
    addr <= 8'h37;
    wr <= 1'b1;
    wd <= v;
    @(posedge clk);
    wr <= 1'b0;
    repeat (70) @(posedge clk);
    master_irq_enable <= keep;
  endtask : wr_ctrl

  task automatic clr(input int i);
    @(posedge clk);
    clr_v <= 5'h01 << i;
    @(posedge clk);
    clr_v <= 5'h00;
  endtask : clr

  task automatic xq(input logic [7:0] op, input logic u, input logic et, input logic eb);
    @(posedge clk);
    xv <= 1'b1;
    xop <= op;
    xund <= u;
    @(posedge clk);
    xv <= 1'b0;
    @(negedge clk);
    chk("trap_bad", {6'h00, et, eb}, {6'h00, trap, bad});
  endtask : xq

  task automatic fq(input logic [15:0] a, input logic ex, input logic r,
                    input logic [7:0] ed, input logic [1:0] eg);
    @(posedge clk);
    fetch <= 1'b1;
    faddr <= a;
    fex <= ex;
    ram <= r;
    @(posedge clk);
    fetch <= 1'b0;
    @(negedge clk);
    chk("fetch_data", ed, fdata);
    chk("guard_irq_rst", {6'h00, eg}, {6'h00, gi, gr});
  endtask : fq

  // pending seen after a rise, after a clear while high, and after the fall
  task automatic edge_run(input int i, input int win, input logic [2:0] e);
    src.set_pin(i, 1'b1);
    settle(win);
    chk("pend_high", 8'(e[2]), 8'(pend[i]));
    clr(i);
    settle(3);
    chk("pend_held", 8'(e[1]), 8'(pend[i]));
    src.set_pin(i, 1'b0);
    settle(win);
    chk("pend_low", 8'(e[0]), 8'(pend[i]));
    clr(i);
    settle(3);
  endtask : edge_run

  task automatic pulse_run(input int i, input int w, input int win, input logic e);
    src.pulse(i, w);
    settle(win);
    chk("pend_pulse", 8'(e), 8'(pend[i]));
    clr(i);
  endtask : pulse_run

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    close_out();
  end

  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    settle(1);
    chk("port_is", 8'h01, 8'(port_is));
    chk("fetch_reset", 8'hff, fdata);
    chk("pend_reset", 8'h00, 8'(pend));
    rd(8'h37, 8'h00);
    rd(8'h36, 8'h00);
    wr_ctrl(8'hff);
    rd(8'h37, 8'hfe);
    chk("port_is", 8'h00, 8'(port_is));
    xq(8'hff, 1'b0, 1'b1, 1'b0);
    xq(8'h13, 1'b1, 1'b0, 1'b1);
    xq(8'h12, 1'b0, 1'b0, 1'b0);
    fq(16'h1000, 1'b0, 1'b0, 8'hff, 2'b00);
    fq(16'h1000, 1'b1, 1'b0, 8'h5a, 2'b00);
    fq(16'h0000, 1'b1, 1'b0, 8'h5a, 2'b10);
    fq(16'h003f, 1'b1, 1'b0, 8'h5a, 2'b10);
    fq(16'h0040, 1'b1, 1'b0, 8'h5a, 2'b00);
    fq(16'h0f7f, 1'b1, 1'b0, 8'h5a, 2'b00);
    fq(16'h0f80, 1'b1, 1'b0, 8'h5a, 2'b10);
    fq(16'h0fff, 1'b1, 1'b0, 8'h5a, 2'b10);
    fq(16'h0200, 1'b1, 1'b1, 8'h5a, 2'b10);
    gsel <= 1'b1;
    fq(16'h0010, 1'b1, 1'b0, 8'h5a, 2'b01);
    gsel <= 1'b0;
    // every trigger code on c and d
    for (int m = 0; m < 4; m++) begin
      wr_ctrl({2'b01, 2'(m), 2'(m), 2'b00});
      edge_run(2, 20, pat[m]);
      edge_run(3, 20, pat[m]);
    end
    wr_ctrl(8'h40);
    edge_run(0, 20, 3'b001);
    edge_run(4, 20, 3'b001);
    pulse_run(4, 2, 20, 1'b0);
    pulse_run(0, 10, 20, 1'b1);
    pulse_run(3, 6, 20, 1'b0);
    master_irq_enable <= 1'b0;
    pulse_run(4, 10, 20, 1'b0);
    master_irq_enable <= 1'b1;
    en <= 5'h0f;
    pulse_run(4, 10, 20, 1'b0);
    en <= 5'h1f;
    lvl <= 1'b0;
    pulse_run(2, 12, 20, 1'b0);
    lvl <= 1'b1;
    // pending holds until accepted
    src.pulse(4, 10);
    settle(60);
    chk("pend_hold", 8'h01, 8'(pend[4]));
    @(posedge clk);
    acc <= 5'h10;
    @(posedge clk);
    acc <= 5'h00;
    settle(1);
    chk("pend_accept", 8'h00, 8'(pend[4]));
    wr_ctrl(8'h00);
    pulse_run(0, 10, 20, 1'b0);
    wr_ctrl(8'hc0);
    pulse_run(1, 30, 80, 1'b1);
    pulse_run(1, 12, 80, 1'b0);
    wr_ctrl(8'h40);
    pulse_run(1, 30, 80, 1'b0);
    pulse_run(1, 70, 90, 1'b1);
    edge_run(1, 80, 3'b100);
    wr_ctrl(8'h42);
    edge_run(1, 80, 3'b001);
    slow <= 1'b1;
    pulse_run(4, 40, 60, 1'b1);
    pulse_run(4, 3, 60, 1'b0);
    close_out();
  end
endmodule : isfe_front_end_tb_top
